/* verilog/lce_map.svh */
// Purpose: named constants of the command executor (opcodes, offsets, fields, times)
// Assumes: included by its bare name; definitions only
// Notes: times are kept in their own unit; cycle counts are derived in the top module
`ifndef LCE_MAP_SVH
`define LCE_MAP_SVH

// -----------------------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------------------
`define LCE_OP_READ_PAGE 8'h33
`define LCE_OP_SPEC_TEST 8'h44
`define LCE_OP_MEASURE 8'h55
`define LCE_OP_CLEAR 8'hA5

// -----------------------------------------------------------------------------
// page, pulse train, timing
// -----------------------------------------------------------------------------
`define LCE_PAGE_LAST 5'h1F
`define LCE_SPEC_PULSES 4
`define LCE_CLK_MHZ 25
`define LCE_PULSE_LOW_MS 62.5
`define LCE_PULSE_PERIOD_S 0.5
`define LCE_QUIET_US 500
`define LCE_TIMER_W 24
`define LCE_CRC_POLY 16'hA001
`define LCE_CRC_INIT 16'h0000

// -----------------------------------------------------------------------------
// register offsets and fields
// -----------------------------------------------------------------------------
`define LCE_REG_CTRL 12'h000
`define LCE_REG_STATUS 12'h004
`define LCE_CTRL_CLR_BIT 0
`define LCE_CTRL_CS_LSB 4
`define LCE_STAT_DONE_BIT 0
`define LCE_STAT_MEMCLR_BIT 1
`define LCE_STAT_BUSY_BIT 2
`define LCE_STAT_SPEC_BIT 3

`endif

/* verilog/lce_pkg.sv */
// Purpose: types of the command executor
// Assumes: lce_map.svh gives the widths
// Notes: none
`include "lce_map.svh"

package lce_pkg;

    // -------------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------------
    typedef enum logic [3:0] {
        LCE_IDLE, LCE_ADDR_HI, LCE_ADDR_LO, LCE_LOAD, LCE_SEND,
        LCE_CRC_HI, LCE_CRC_LO, LCE_SERVE, LCE_QUIET
    } lce_state_t;

    typedef struct packed {
        logic [3:0] channelSelect;
        logic clearEnable;
    } lce_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } lce_byte_t;

    typedef logic [`LCE_TIMER_W-1:0] lce_timer_t;

endpackage

/* verilog/lce_command_executor.sv */
// Purpose: executes page read, limit check, measure-now and clear commands
// Assumes: uart framing, memory, measurement and logging engines sit outside
// Notes: the 3-wire side runs on linkClk; the rest runs on sys_clk
`include "lce_map.svh"
`timescale 1ns/1ns
`default_nettype none

module lce_command_executor import lce_pkg::*; #(
    parameter int unsigned PULSE_LOW_CYCLES =
        int'(`LCE_PULSE_LOW_MS * 1000.0 * `LCE_CLK_MHZ),
    parameter int unsigned PULSE_PERIOD_CYCLES =
        int'(`LCE_PULSE_PERIOD_S * 1000000.0 * `LCE_CLK_MHZ),
    parameter int unsigned QUIET_CYCLES = `LCE_QUIET_US * `LCE_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic commSelectAsync,
    input wire lce_byte_t uartRx,
    output lce_byte_t uartTx,
    input wire logic uartTxReady,
    output logic uartTxActive,
    input wire logic linkClk,
    input wire logic linkSelect,
    input wire logic linkDataIn,
    output logic linkDataOut,
    output logic linkDataOe,
    output logic [15:0] memAddr,
    input wire logic [7:0] memRdData,
    input wire logic statusButtonInput,
    input wire logic loggingActiveFlag,
    input wire logic oscillatorRunning,
    input wire logic limitsExceeded,
    output logic withinLimitsIndicatorN,
    output logic limitViolationIndicatorN,
    output logic measureStart,
    output logic [3:0] measureChannels,
    input wire logic measureDone,
    output logic clearStrobe
);

    // -------------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------------
    localparam int unsigned TIMER_MAX = (1 << `LCE_TIMER_W) - 1;
    if (PULSE_LOW_CYCLES == 0 || PULSE_LOW_CYCLES >= PULSE_PERIOD_CYCLES ||
        PULSE_PERIOD_CYCLES > TIMER_MAX || QUIET_CYCLES == 0 ||
        QUIET_CYCLES > TIMER_MAX) begin : g_bad_params
        $error("lce_command_executor: timing parameters out of range");
    end

    localparam lce_timer_t PULSE_LOW = lce_timer_t'(PULSE_LOW_CYCLES);
    localparam lce_timer_t PERIOD_LAST = lce_timer_t'(PULSE_PERIOD_CYCLES - 1);
    localparam lce_timer_t QUIET_LAST = lce_timer_t'(QUIET_CYCLES - 1);
    localparam logic [1:0] SPEC_LAST = 2'(`LCE_SPEC_PULSES - 1);

    // -------------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------------
    lce_state_t state;
    lce_ctrl_t ctrl;
    logic [7:0] pageBuf [32];
    logic [7:0] addrHi;
    logic [4:0] startOff;
    logic [4:0] loadCnt;
    logic [4:0] sendIdx;
    logic [15:0] crc;
    lce_timer_t quietCnt;
    logic pageReady;
    logic specReq;
    logic measureReq;
    logic clearReq;
    logic conversionDone;
    logic memoryCleared;
    logic specActive;
    logic specViolation;
    lce_timer_t specTimer;
    logic [1:0] specCount;
    logic specLowNow;
    logic modeMeta, modeSync;
    logic selMeta, selSync;
    logic buttonMeta, buttonSync;
    logic togMeta, togSync, togSeen;
    logic rxStrobe;
    logic [7:0] rxData;
    logic apbWrite;
    logic [7:0] linkShift;
    logic [2:0] linkBit;
    logic [7:0] linkRxHold;
    logic linkRxToggle;
    logic [7:0] linkCmd;
    logic [1:0] linkByteCnt;
    logic [4:0] linkStart;
    logic readyMeta, readySync;
    logic [7:0] linkByteNow;
    logic linkReading;
    logic linkTxStarted;
    logic [4:0] linkTxIdx;
    logic [2:0] linkTxBit;
    logic [4:0] linkCurIdx;

    // reflected crc16 over one byte, lsb first
    function automatic logic [15:0] lceCrcByte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 8; i++) begin
            fb = r[0] ^ d[i];
            r = r >> 1;
            if (fb) begin
                r = r ^ `LCE_CRC_POLY;
            end
        end
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // synchronisers into sys_clk
    // -------------------------------------------------------------------------
    // pins and link-domain levels, two flops each
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            modeMeta <= 1'b0;
            modeSync <= 1'b0;
            selMeta <= 1'b0;
            selSync <= 1'b0;
            buttonMeta <= 1'b0;
            buttonSync <= 1'b0;
            togMeta <= 1'b0;
            togSync <= 1'b0;
            togSeen <= 1'b0;
        end else begin
            modeMeta <= commSelectAsync;
            modeSync <= modeMeta;
            selMeta <= linkSelect;
            selSync <= selMeta;
            buttonMeta <= statusButtonInput;
            buttonSync <= buttonMeta;
            togMeta <= linkRxToggle;
            togSync <= togMeta;
            togSeen <= togSync;
        end
    end

    // byte source: uart bytes in async mode, crossed link bytes otherwise
    assign rxStrobe = modeSync ? uartRx.valid : (togSync ^ togSeen);
    assign rxData = modeSync ? uartRx.data : linkRxHold;

    // -------------------------------------------------------------------------
    // command sequencer
    // -------------------------------------------------------------------------
    // opcode decode, page fetch, async send with checksum, quiet time
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= LCE_IDLE;
            addrHi <= 8'h00;
            startOff <= 5'h00;
            loadCnt <= 5'h00;
            sendIdx <= 5'h00;
            memAddr <= 16'h0000;
            pageReady <= 1'b0;
            uartTx <= '0;
            uartTxActive <= 1'b0;
            crc <= `LCE_CRC_INIT;
            quietCnt <= '0;
            specReq <= 1'b0;
            measureReq <= 1'b0;
            clearReq <= 1'b0;
        end else begin
            specReq <= 1'b0;
            measureReq <= 1'b0;
            clearReq <= 1'b0;
            if (!modeSync && !selSync && state != LCE_QUIET) begin
                state <= LCE_IDLE;
                pageReady <= 1'b0;
            end else begin
                unique case (state)
                    LCE_IDLE: begin
                        if (rxStrobe) begin
                            case (rxData)
                                `LCE_OP_READ_PAGE: state <= LCE_ADDR_HI;
                                `LCE_OP_SPEC_TEST: specReq <= buttonSync;
                                `LCE_OP_MEASURE: measureReq <= !loggingActiveFlag;
                                `LCE_OP_CLEAR: begin
                                    if (ctrl.clearEnable && oscillatorRunning) begin
                                        clearReq <= 1'b1;
                                        quietCnt <= '0;
                                        state <= LCE_QUIET;
                                    end
                                end
                                default: state <= LCE_IDLE;
                            endcase
                        end
                    end
                    LCE_ADDR_HI: begin
                        if (rxStrobe) begin
                            addrHi <= rxData;
                            state <= LCE_ADDR_LO;
                        end
                    end
                    LCE_ADDR_LO: begin
                        if (rxStrobe) begin
                            startOff <= rxData[4:0];
                            memAddr <= {addrHi, rxData[7:5], 5'h00};
                            loadCnt <= 5'h00;
                            state <= LCE_LOAD;
                        end
                    end
                    LCE_LOAD: begin
                        memAddr <= memAddr + 16'h0001;
                        loadCnt <= loadCnt + 5'h01;
                        if (loadCnt == `LCE_PAGE_LAST) begin
                            if (modeSync) begin
                                sendIdx <= startOff;
                                crc <= `LCE_CRC_INIT;
                                uartTxActive <= 1'b1;
                                state <= LCE_SEND;
                            end else begin
                                pageReady <= 1'b1;
                                state <= LCE_SERVE;
                            end
                        end
                    end
                    LCE_SEND: begin
                        if (!uartTx.valid) begin
                            uartTx <= {1'b1, pageBuf[sendIdx]};
                            crc <= lceCrcByte(crc, pageBuf[sendIdx]);
                        end else if (uartTxReady) begin
                            uartTx.valid <= 1'b0;
                            sendIdx <= sendIdx + 5'h01;
                            if (sendIdx == `LCE_PAGE_LAST) begin
                                state <= LCE_CRC_HI;
                            end
                        end
                    end
                    LCE_CRC_HI: begin
                        if (!uartTx.valid) begin
                            uartTx <= {1'b1, crc[15:8]};
                        end else if (uartTxReady) begin
                            uartTx.valid <= 1'b0;
                            state <= LCE_CRC_LO;
                        end
                    end
                    LCE_CRC_LO: begin
                        if (!uartTx.valid) begin
                            uartTx <= {1'b1, crc[7:0]};
                        end else if (uartTxReady) begin
                            uartTx.valid <= 1'b0;
                            uartTxActive <= 1'b0;
                            state <= LCE_IDLE;
                        end
                    end
                    LCE_SERVE: state <= LCE_SERVE;
                    LCE_QUIET: begin
                        if (quietCnt == QUIET_LAST) begin
                            state <= LCE_IDLE;
                        end else begin
                            quietCnt <= quietCnt + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // page buffer, filled during the fetch; combinational memory read
    always_ff @(posedge sys_clk) begin
        if (state == LCE_LOAD) begin
            pageBuf[loadCnt] <= memRdData;
        end
    end

    // -------------------------------------------------------------------------
    // measure-now and clear side effects
    // -------------------------------------------------------------------------
    // start pulse to the measurement engine; only current-value registers load
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            measureStart <= 1'b0;
            measureChannels <= 4'h0;
            conversionDone <= 1'b0;
        end else begin
            measureStart <= measureReq;
            if (measureReq) begin
                measureChannels <= ctrl.channelSelect;
            end
            if (measureDone) begin
                conversionDone <= 1'b1;
            end else if (measureReq) begin
                conversionDone <= 1'b0;
            end
        end
    end

    // wipe strobe and cleared flag; set beats a software clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clearStrobe <= 1'b0;
            memoryCleared <= 1'b0;
        end else begin
            clearStrobe <= clearReq;
            if (clearStrobe) begin
                memoryCleared <= 1'b1;
            end else if (apbWrite && paddr == `LCE_REG_STATUS &&
                         pwdata[`LCE_STAT_MEMCLR_BIT]) begin
                memoryCleared <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // limit-check pulse train
    // -------------------------------------------------------------------------
    assign specLowNow = specActive && (specTimer < PULSE_LOW);

    // four periods, low phase first, indicator chosen at start
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            specActive <= 1'b0;
            specViolation <= 1'b0;
            specTimer <= '0;
            specCount <= 2'h0;
            withinLimitsIndicatorN <= 1'b1;
            limitViolationIndicatorN <= 1'b1;
        end else begin
            if (specReq && !specActive) begin
                specActive <= 1'b1;
                specViolation <= limitsExceeded;
                specTimer <= '0;
                specCount <= 2'h0;
            end else if (specActive) begin
                if (specTimer == PERIOD_LAST) begin
                    specTimer <= '0;
                    specCount <= specCount + 2'h1;
                    if (specCount == SPEC_LAST) begin
                        specActive <= 1'b0;
                    end
                end else begin
                    specTimer <= specTimer + 1'b1;
                end
            end
            withinLimitsIndicatorN <= !(specLowNow && !specViolation);
            limitViolationIndicatorN <= !(specLowNow && specViolation);
        end
    end

    // -------------------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------------------
    assign apbWrite = psel && penable && pready && pwrite;

    // no wait state: answer prepared in setup, completed in the first access cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                if (paddr == `LCE_REG_CTRL) begin
                    prdata[`LCE_CTRL_CLR_BIT] <= ctrl.clearEnable;
                    prdata[`LCE_CTRL_CS_LSB +: 4] <= ctrl.channelSelect;
                end else if (paddr == `LCE_REG_STATUS) begin
                    prdata[`LCE_STAT_DONE_BIT] <= conversionDone;
                    prdata[`LCE_STAT_MEMCLR_BIT] <= memoryCleared;
                    prdata[`LCE_STAT_BUSY_BIT] <= (state != LCE_IDLE);
                    prdata[`LCE_STAT_SPEC_BIT] <= specActive;
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (apbWrite && paddr == `LCE_REG_CTRL) begin
                ctrl.clearEnable <= pwdata[`LCE_CTRL_CLR_BIT];
                ctrl.channelSelect <= pwdata[`LCE_CTRL_CS_LSB +: 4];
            end
        end
    end

    // -------------------------------------------------------------------------
    // 3-wire link, linkClk domain, reset while select is low
    // -------------------------------------------------------------------------
    assign linkByteNow = {linkDataIn, linkShift[7:1]};
    assign linkReading = (linkCmd == `LCE_OP_READ_PAGE) && (linkByteCnt == 2'h3) && readySync;
    assign linkCurIdx = linkTxStarted ? linkTxIdx : linkStart;

    // receive on rising edges, lsb first; bytes cross by toggle
    always_ff @(posedge linkClk or negedge linkSelect) begin
        if (!linkSelect) begin
            linkShift <= 8'h00;
            linkBit <= 3'h0;
            linkRxHold <= 8'h00;
            linkRxToggle <= 1'b0;
            linkCmd <= 8'h00;
            linkByteCnt <= 2'h0;
            linkStart <= 5'h00;
            readyMeta <= 1'b0;
            readySync <= 1'b0;
        end else begin
            readyMeta <= pageReady;
            readySync <= readyMeta;
            linkShift <= linkByteNow;
            linkBit <= linkBit + 3'h1;
            if (linkBit == 3'h7) begin
                linkRxHold <= linkByteNow;
                linkRxToggle <= !linkRxToggle;
                if (linkByteCnt == 2'h0) begin
                    linkCmd <= linkByteNow;
                end
                if (linkByteCnt == 2'h2) begin
                    linkStart <= linkByteNow[4:0];
                end
                if (linkByteCnt != 2'h3) begin
                    linkByteCnt <= linkByteCnt + 2'h1;
                end
            end
        end
    end

    // transmit on falling edges, lsb first, wrapping inside the page
    always_ff @(negedge linkClk or negedge linkSelect) begin
        if (!linkSelect) begin
            linkDataOut <= 1'b0;
            linkDataOe <= 1'b0;
            linkTxStarted <= 1'b0;
            linkTxIdx <= 5'h00;
            linkTxBit <= 3'h0;
        end else if (linkReading) begin
            linkDataOut <= pageBuf[linkCurIdx][linkTxBit];
            linkDataOe <= 1'b1;
            linkTxStarted <= 1'b1;
            linkTxBit <= linkTxBit + 3'h1;
            if (linkTxBit == 3'h7) begin
                linkTxIdx <= linkCurIdx + 5'h01;
            end else begin
                linkTxIdx <= linkCurIdx;
            end
        end
    end

endmodule

`default_nettype wire

/* tb/lce_host_model.sv */
// Purpose: far side: register set, tx sink, engine
// Assumes: sys_clk domain only
// Notes: ready stalls at random
`timescale 1ns/1ns
`default_nettype none
module lce_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] memAddr,
    output logic [7:0] memRdData,
    output logic uartTxReady,
    input wire logic measureStart,
    output var logic measureDone = 1'h0
);
    // register contents follow the address at once
    assign memRdData = memAddr[7:0] ^ 8'hC3;
    // random tx stalls, done 40 cycles after start
    always @(posedge sys_clk) begin
        uartTxReady <= 1'($urandom % 2);
        measureDone <= 1'h0;
        if (measureStart === 1'h1) begin
            repeat (40) @(posedge sys_clk);
            measureDone <= 1'h1;
        end
    end
endmodule
`default_nettype wire

/* tb/lce_command_executor_chk.sv */
// Purpose: port checks of the command executor
// Assumes: bound to the top module
// Notes: low width matches the bench count of 5
`timescale 1ns/1ns
`default_nettype none
module lce_command_executor_chk import lce_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic loggingActiveFlag,
    input wire logic oscillatorRunning,
    input wire logic linkSelect,
    input wire logic linkDataOe,
    input wire lce_byte_t uartTx,
    input wire logic uartTxReady,
    input wire logic uartTxActive,
    input wire logic withinLimitsIndicatorN,
    input wire logic limitViolationIndicatorN,
    input wire logic measureStart,
    input wire logic clearStrobe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // one low pulse, then high again
    sequence lowPulse(s);
        (!s) [*5] ##1 s;
    endsequence
    a_clear_pulse: assert property (clearStrobe |=> !clearStrobe)
        else $error("clear strobe long");
    a_clear_osc: assert property (clearStrobe |-> $past(oscillatorRunning, 2))
        else $error("clear without oscillator");
    a_meas_blocked: assert property (measureStart |-> !$past(loggingActiveFlag, 2))
        else $error("measure while logging");
    a_in_width: assert property ($fell(withinLimitsIndicatorN) |-> lowPulse(withinLimitsIndicatorN))
        else $error("within pulse width");
    a_out_width: assert property ($fell(limitViolationIndicatorN) |-> lowPulse(limitViolationIndicatorN))
        else $error("violation pulse width");
    a_one_pin: assert property (withinLimitsIndicatorN || limitViolationIndicatorN)
        else $error("both indicators low");
    a_link_release: assert property (!linkSelect |-> !linkDataOe)
        else $error("data line held");
    a_tx_hold: assert property (uartTx.valid && !uartTxReady |=> uartTx.valid && $stable(uartTx.data))
        else $error("tx byte dropped");
    a_tx_active: assert property (uartTx.valid |-> uartTxActive)
        else $error("tx inactive");
endmodule
bind lce_command_executor lce_command_executor_chk chk (.*);
`default_nettype wire

/* tb/lce_command_executor_tb.sv */
// Purpose: bench for the command executor
// Assumes: uart mode, link command and link page read at the end
// Notes: short pulse and quiet counts
`timescale 1ns/1ns
`default_nettype none
module lce_command_executor_tb import lce_pkg::*;;
    logic sys_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, uartTxReady, uartTxActive, linkDataOut, linkDataOe;
    logic withinLimitsIndicatorN, limitViolationIndicatorN, measureStart, measureDone;
    logic clearStrobe, commSelectAsync = 1'h1, linkClk = 1'h0, linkSelect = 1'h1;
    logic linkDataIn = 1'h0, statusButtonInput = 1'h1, loggingActiveFlag = 1'h0;
    logic oscillatorRunning = 1'h1, limitsExceeded = 1'h1;
    lce_byte_t uartRx = 9'h0, uartTx;
    logic [15:0] memAddr;
    logic [7:0] memRdData, lrx, expQ[$];
    logic [3:0] measureChannels;
    int n_mismatch = 0, checked = 0, nMeas = 0, nClr = 0, nIn = 0, nViol = 0;
    lce_command_executor #(.PULSE_LOW_CYCLES(5), .PULSE_PERIOD_CYCLES(20),
        .QUIET_CYCLES(16)) dut (.*);
    lce_host_model host (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask
    // link cycles: bits lsb first, data out taken at each rising edge
    task automatic lclk(input int n, input logic [7:0] b);
        for (int j = 0; j < n; j++) begin
            linkDataIn = b[j % 8];
            #15 linkClk = 1'h1;
            lrx = {linkDataOut, lrx[7:1]};
            #15 linkClk = 1'h0;
        end
    endtask
    task automatic ubyte(input logic [7:0] b);
        uartRx <= {1'h1, b};
        @(posedge sys_clk);
        uartRx <= 9'h0;
        repeat (12) @(posedge sys_clk);
    endtask
    // page read: note bytes and crc, then ask
    task automatic page(input logic [4:0] s);
        logic [15:0] c;
        logic [7:0] b;
        c = 16'h0;
        for (int i = s; i < 32; i++) begin
            b = 8'(8'h40 + i) ^ 8'hC3;
            expQ.push_back(b);
            for (int j = 0; j < 8; j++)
                c = (c[0] ^ b[j]) ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        expQ.push_back(c[15:8]);
        expQ.push_back(c[7:0]);
        ubyte(8'h33);
        ubyte(8'h01);
        ubyte(8'h40 | s);
        for (int t = 0; t < 400 && expQ.size() > 0; t++) @(posedge sys_clk);
        check(expQ.size(), 0, "page length");
    endtask
    // outputs seen at each edge
    always @(posedge sys_clk) begin
        nMeas += int'(measureStart === 1'h1);
        nClr += int'(clearStrobe === 1'h1);
        if (uartTx.valid === 1'h1 && uartTxReady === 1'h1)
            check(uartTx.data, expQ.size() ? expQ.pop_front() : 9'h1FF, "tx byte");
    end
    always @(negedge withinLimitsIndicatorN) nIn++;
    always @(negedge limitViolationIndicatorN) nViol++;
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
    initial begin
        void'($urandom(32'hE122));
        linkSelect <= 1'h0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        apb(1'h0, 12'hFFC, 32'h0);
        check(err, 1'h1, "unmapped");
        apb(1'h1, 12'h000, 32'hA0);
        page(5'(28 + $urandom % 4));
        repeat (5) @(posedge sys_clk);
        check(uartTxActive, 1'h0, "tx idle");
        ubyte(8'h55);
        apb(1'h0, 12'h004, 32'h0);
        check(rd[0], 1'h0, "pending");
        repeat (50) @(posedge sys_clk);
        apb(1'h0, 12'h004, 32'h0);
        check({rd[0], measureChannels}, 5'h1A, "done");
        loggingActiveFlag <= 1'h1;
        ubyte(8'h55);
        loggingActiveFlag <= 1'h0;
        ubyte(8'h77);
        check(nMeas, 1, "measures");
        // violation, within, then button held low
        for (int k = 0; k < 3; k++) begin
            limitsExceeded <= 1'(k == 0);
            statusButtonInput <= 1'(k < 2);
            repeat (4) @(posedge sys_clk);
            ubyte(8'h44);
            repeat (100) @(posedge sys_clk);
        end
        check({nViol[7:0], nIn[7:0]}, 16'h0404, "pulses");
        apb(1'h1, 12'h000, 32'hA1);
        oscillatorRunning <= 1'h0;
        ubyte(8'hA5);
        oscillatorRunning <= 1'h1;
        ubyte(8'hA5);
        ubyte(8'h55);
        check({nClr[3:0], nMeas[3:0]}, 8'h11, "clear");
        apb(1'h0, 12'h004, 32'h0);
        check(rd[1], 1'h1, "cleared");
        apb(1'h1, 12'h000, 32'hA0);
        ubyte(8'hA5);
        check(nClr, 1, "clear off");
        commSelectAsync <= 1'h0;
        repeat (4) @(posedge sys_clk);
        linkSelect <= 1'h1;
        #1000 lclk(8, 8'h55);
        #600 check(nMeas, 2, "link command");
        linkSelect <= 1'h0;
        #1000 linkSelect <= 1'h1;
        // link page read from offset 31, then wrap to offset 0
        #1000 lclk(8, 8'h33);
        lclk(8, 8'h01);
        lclk(8, 8'h5F);
        #3000 lclk(2, 8'h00);
        lclk(8, 8'h00);
        check(lrx, 8'h9C, "link last");
        lclk(8, 8'h00);
        check(lrx, 8'h83, "link wrap");
        check(linkDataOe, 1'h1, "driving");
        linkSelect <= 1'h0;
        #1 check(linkDataOe, 1'h0, "released");
        summarize();
    end
endmodule
`default_nettype wire
